// ---- scr_pkg.sv ----
// Shared constants, enumerations and carriers of the system clock, reset and mode unit.
package scr_pkg;

	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CHIP_ID              = 8'h00;
	localparam logic [7:0] OFS_SYSTEM_MODE          = 8'h04;
	localparam logic [7:0] OFS_SW_RESET             = 8'h08;
	localparam logic [7:0] OFS_RESET_SRC_ENABLE     = 8'h18;
	localparam logic [7:0] OFS_RESET_SRC_STATUS     = 8'h1c;
	localparam logic [7:0] OFS_PERIPH_RESET_ENABLE  = 8'h20;
	localparam logic [7:0] OFS_PERIPH_FUNC_ENABLE   = 8'h28;
	localparam logic [7:0] OFS_PERIPH_CLOCK_GATE    = 8'h30;
	localparam logic [7:0] OFS_CLOCK_SOURCE_CONTROL = 8'h40;
	localparam logic [7:0] OFS_CLOCK_SELECT         = 8'h44;
	localparam logic [7:0] OFS_SYNTH_CONTROL        = 8'h60;
	localparam logic [7:0] OFS_FLASH_MEMORY_CONTROL = 8'h88;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int SRC_CTL_FAST_BIT  = 0;
	localparam int SRC_CTL_XTAL_BIT  = 1;
	localparam int SEL_LSB           = 0;
	localparam int MODE_LSB          = 0;
	localparam int PRIOR_MODE_LSB    = 4;
	localparam int SW_RESET_BIT      = 1;
	localparam int SYN_EN_BIT        = 0;
	localparam int SYN_REF_BIT       = 1;
	localparam int SYN_PRE_LSB       = 4;
	localparam int SYN_MULT_LSB      = 8;
	localparam int SYN_POST_LSB      = 16;
	localparam int SYN_LOCK_BIT      = 31;
	localparam int STATUS_POR_BIT    = 7;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [31:0] CHIP_ID_VAL     = 32'h5a5a_0001; // Arbitrary value.
	localparam logic [6:0]  RESET_EN_RST    = 7'h49;
	localparam logic [7:0]  RESET_STAT_RST  = 8'h80;
	localparam logic [31:0] PRST_EN_RST     = 32'h03ff_1f1f;
	localparam logic [31:0] PFUNC_EN_RST    = 32'h0000_000f;
	localparam logic [31:0] PCLK_GATE_RST   = 32'h0000_000f;
	localparam logic [3:0]  SYN_PRE_RST     = 4'h1;
	localparam logic [7:0]  SYN_MULT_RST    = 8'h10;
	localparam logic [3:0]  SYN_POST_RST    = 4'h4;
	localparam logic        FLASH_FOUR_RST  = 1'b1;
	localparam logic [1:0]  PRIOR_MODE_RST  = 2'h0;

	// ---------------------------------------------------------------
	// Frequencies and timing
	// ---------------------------------------------------------------
	localparam int          SYS_CLK_MHZ       = 50;
	localparam int          RING_MHZ          = 1;
	localparam int          POR_TIME_US       = 4000;
	localparam int          POR_RING_TICKS    = POR_TIME_US * RING_MHZ;
	localparam int          SYN_LOCK_TIME_US  = 50;
	localparam int          SYN_LOCK_CYCLES   = SYN_LOCK_TIME_US * SYS_CLK_MHZ;
	localparam int          WARM_HOLD_CYCLES  = 16;
	localparam int          XTAL_MHZ          = 8;
	localparam logic [7:0]  FAST_MHZ          = 8'h14;
	localparam logic [15:0] SYN_MIN_MHZ       = 16'h0008;
	localparam logic [15:0] SYN_MAX_MHZ       = 16'h0050;

	// ---------------------------------------------------------------
	// Enumerations and carriers
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		SRC_RING = 2'b00,
		SRC_FAST = 2'b01,
		SRC_XTAL = 2'b10,
		SRC_SYN  = 2'b11
	} scr_src_e;

	typedef enum logic [1:0] {
		MODE_RUN   = 2'b00,
		MODE_SLEEP = 2'b01,
		MODE_PDOWN = 2'b10,
		MODE_INIT  = 2'b11
	} scr_mode_e;

	typedef enum logic [1:0] {
		RST_POR_WAIT = 2'b00,
		RST_ACTIVE   = 2'b01,
		RST_WARM     = 2'b10
	} scr_rst_e;

	typedef enum logic [1:0] {
		SW_PASS  = 2'b00,
		SW_DRAIN = 2'b01,
		SW_ARM   = 2'b10
	} scr_sw_e;

	typedef struct packed {
		logic free_running_core_clock_en;
		logic hclk_en;
		logic pclk_en;
	} scr_clk_s;

	typedef struct packed {
		logic       en;
		logic       ref_sel;
		logic [3:0] pre;
		logic [7:0] mult;
		logic [3:0] post;
	} scr_synth_cfg_s;

endpackage

// ---- scr_clk_switch.sv ----
// Glitch-free switch between clock source ticks.
`timescale 1ns/1ns
`default_nettype none
module scr_clk_switch (
	input  wire logic             i_sys_clk,
	input  wire logic             i_reset,
	input  wire logic [3:0]       i_src_tick,
	input  wire scr_pkg::scr_src_e i_sel,
	output logic                  o_tick,
	output logic                  o_busy,
	output scr_pkg::scr_src_e     o_cur
);

	scr_pkg::scr_sw_e  state_r;
	scr_pkg::scr_src_e cur_r;
	scr_pkg::scr_src_e tgt_r;
	logic              tick_r;

	wire cur_tick = i_src_tick[cur_r];

	// ---------------------------------------------------------------
	// Switch sequence
	// ---------------------------------------------------------------
	// The old source is closed only on its own edge and the new one
	// opened only after its first edge, so no period is ever shortened.
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			state_r <= scr_pkg::SW_PASS;
			cur_r   <= scr_pkg::SRC_RING;
			tgt_r   <= scr_pkg::SRC_RING;
			tick_r  <= 1'b0;
		end else begin
			tick_r <= (state_r == scr_pkg::SW_PASS) && cur_tick;
			case (state_r)
				scr_pkg::SW_PASS: begin
					if (i_sel != cur_r) begin
						tgt_r   <= i_sel;
						state_r <= scr_pkg::SW_DRAIN;
					end
				end
				scr_pkg::SW_DRAIN: begin
					if (cur_tick) begin
						cur_r   <= tgt_r;
						state_r <= scr_pkg::SW_ARM;
					end
				end
				scr_pkg::SW_ARM: begin
					if (cur_tick) begin
						state_r <= scr_pkg::SW_PASS;
					end
				end
				default: begin
					state_r <= scr_pkg::SW_PASS;
				end
			endcase
		end
	end

	assign o_tick = tick_r;
	assign o_busy = (state_r != scr_pkg::SW_PASS);
	assign o_cur  = cur_r;

endmodule
`default_nettype wire

// ---- scr_sys_ctrl.sv ----
// System clock source selection, reset sequencing and operating mode control.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module scr_sys_ctrl #(
	parameter int unsigned P_POR_RING_TICKS  = scr_pkg::POR_RING_TICKS,
	parameter int unsigned P_SYN_LOCK_CYCLES = scr_pkg::SYN_LOCK_CYCLES,
	parameter int unsigned P_XTAL_MHZ        = scr_pkg::XTAL_MHZ
) (
	input  wire logic                   i_sys_clk,
	input  wire logic                   i_reset,
	input  wire logic [7:0]             i_addr,
	input  wire logic [31:0]            i_wdata,
	input  wire logic                   i_wr,
	input  wire logic                   i_rd,
	output logic [31:0]                 o_rdata,
	input  wire logic [3:0]             i_osc_clk,
	output logic [3:0]                  o_osc_en,
	output scr_pkg::scr_synth_cfg_s     o_synth_cfg,
	input  wire logic                   i_external_reset_n_pin,
	input  wire logic                   i_wdt_rst,
	input  wire logic                   i_lvd_rst,
	input  wire logic                   i_mclk_fail,
	input  wire logic                   i_xtal_fail,
	input  wire logic                   i_cpu_req_rst,
	input  wire logic                   i_vdc_drop,
	input  wire logic                   i_core_wfi,
	input  wire logic                   i_wakeup,
	output scr_pkg::scr_clk_s           o_clk_en,
	output logic [31:0]                 o_pclk_gate,
	output logic [31:0]                 o_periph_func_en,
	output logic [31:0]                 o_periph_rst,
	output logic                        o_core_system_reset_n,
	output logic                        o_debug_reset_n,
	output logic                        o_warm_reset,
	output logic                        o_flash_wait_four,
	output scr_pkg::scr_mode_e          o_mode
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	logic [4:0]              sync1_r;
	logic [4:0]              sync2_r;
	logic [3:0]              osc_dly_r;
	scr_pkg::scr_rst_e       rst_state_r;
	logic [15:0]             por_cnt_r;
	logic [4:0]              hold_cnt_r;
	logic [6:0]              rst_en_r;
	logic [7:0]              rst_stat_r;
	logic [7:0]              rst_stat_nxt;
	logic [31:0]             prst_en_r;
	logic [31:0]             pfunc_en_r;
	logic [31:0]             pclk_gate_en_r;
	logic                    fast_en_r;
	logic                    xtal_en_r;
	scr_pkg::scr_src_e       sel_r;
	scr_pkg::scr_src_e       sel_nxt;
	scr_pkg::scr_synth_cfg_s syn_r;
	logic [11:0]             syn_cnt_r;
	logic                    flash_four_r;
	scr_pkg::scr_mode_e      mode_r;
	logic [1:0]              prior_mode_r;
	logic                    sleep_arm_r;
	logic                    pd_arm_r;
	logic                    sw_req_r;
	scr_pkg::scr_clk_s       clk_en_r;
	logic [31:0]             pclk_gate_r;
	logic [31:0]             prst_r;
	logic [31:0]             rdata_r;

	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	wire wr_mode    = i_wr && (i_addr == scr_pkg::OFS_SYSTEM_MODE);
	wire wr_software_reset_bit   = i_wr && (i_addr == scr_pkg::OFS_SW_RESET);
	wire wr_rst_en  = i_wr && (i_addr == scr_pkg::OFS_RESET_SRC_ENABLE);
	wire wr_rst_st  = i_wr && (i_addr == scr_pkg::OFS_RESET_SRC_STATUS);
	wire wr_prst    = i_wr && (i_addr == scr_pkg::OFS_PERIPH_RESET_ENABLE);
	wire wr_pfunc   = i_wr && (i_addr == scr_pkg::OFS_PERIPH_FUNC_ENABLE);
	wire wr_pgate   = i_wr && (i_addr == scr_pkg::OFS_PERIPH_CLOCK_GATE);
	wire wr_src_ctl = i_wr && (i_addr == scr_pkg::OFS_CLOCK_SOURCE_CONTROL);
	wire wr_sel     = i_wr && (i_addr == scr_pkg::OFS_CLOCK_SELECT);
	wire wr_syn     = i_wr && (i_addr == scr_pkg::OFS_SYNTH_CONTROL);
	wire wr_flash   = i_wr && (i_addr == scr_pkg::OFS_FLASH_MEMORY_CONTROL);

	wire in_por   = (rst_state_r == scr_pkg::RST_POR_WAIT);
	wire in_warm  = (rst_state_r == scr_pkg::RST_WARM);
	wire active   = (rst_state_r == scr_pkg::RST_ACTIVE);

	// ---------------------------------------------------------------
	// Pin synchronisers and oscillator edge ticks
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			sync1_r   <= 5'h1f;
			sync2_r   <= 5'h1f;
			osc_dly_r <= 4'hf;
		end else begin
			sync1_r   <= {i_external_reset_n_pin, i_osc_clk};
			sync2_r   <= sync1_r;
			osc_dly_r <= sync2_r[3:0];
		end
	end

	wire [3:0] src_tick = sync2_r[3:0] & ~osc_dly_r & o_osc_en;
	wire       ring_tick = src_tick[scr_pkg::SRC_RING];

	// ---------------------------------------------------------------
	// Reset sources
	// ---------------------------------------------------------------
	wire [6:0] rst_evt = {~sync2_r[4], i_wdt_rst, i_lvd_rst, i_cpu_req_rst,
		sw_req_r, i_mclk_fail, i_xtal_fail};
	wire [6:0] rst_hit  = rst_evt & rst_en_r & {7{active}};
	wire       warm_trig = (|rst_hit) || (i_vdc_drop && !in_por);
	wire [7:0] rst_clr   = wr_rst_st ? i_wdata[7:0] : 8'h00;
	wire [7:0] rst_set   = {i_vdc_drop, rst_hit};

	// Status bits are write-one-to-clear; a new event wins over the clear.
	assign rst_stat_nxt = (rst_stat_r & ~rst_clr) | rst_set;

	// ---------------------------------------------------------------
	// Reset sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			rst_state_r <= scr_pkg::RST_POR_WAIT;
			por_cnt_r   <= 16'h0000;
			hold_cnt_r  <= 5'h00;
		end else begin
			case (rst_state_r)
				scr_pkg::RST_POR_WAIT: begin
					if (ring_tick) begin
						por_cnt_r <= por_cnt_r + 16'h0001;
						if (por_cnt_r == 16'(P_POR_RING_TICKS - 1)) begin
							rst_state_r <= scr_pkg::RST_ACTIVE;
						end
					end
				end
				scr_pkg::RST_ACTIVE: begin
					hold_cnt_r <= 5'h00;
					if (warm_trig) begin
						rst_state_r <= scr_pkg::RST_WARM;
					end
				end
				scr_pkg::RST_WARM: begin
					if (|(rst_evt & rst_en_r) || i_vdc_drop) begin
						hold_cnt_r <= 5'h00;
					end else if (hold_cnt_r == 5'(scr_pkg::WARM_HOLD_CYCLES - 1)) begin
						rst_state_r <= scr_pkg::RST_ACTIVE;
					end else begin
						hold_cnt_r <= hold_cnt_r + 5'h01;
					end
				end
				default: begin
					rst_state_r <= scr_pkg::RST_POR_WAIT;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Registers that survive a warm reset
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			rst_en_r     <= scr_pkg::RESET_EN_RST;
			rst_stat_r   <= scr_pkg::RESET_STAT_RST;
			prst_en_r    <= scr_pkg::PRST_EN_RST;
			prior_mode_r <= scr_pkg::PRIOR_MODE_RST;
		end else begin
			rst_stat_r <= rst_stat_nxt;
			if (wr_rst_en) begin
				rst_en_r <= i_wdata[6:0];
			end
			if (wr_prst) begin
				prst_en_r <= i_wdata;
			end
			if (active && warm_trig) begin
				prior_mode_r <= mode_r;
			end
		end
	end

	// ---------------------------------------------------------------
	// Clock source control
	// ---------------------------------------------------------------
	wire [7:0]  syn_ref   = syn_r.ref_sel ? 8'(P_XTAL_MHZ) : scr_pkg::FAST_MHZ;
	wire [15:0] syn_prod  = 16'(syn_ref * syn_r.mult);
	wire [15:0] syn_div   = 16'(syn_r.pre * syn_r.post);
	wire        syn_range = (syn_prod >= 16'(scr_pkg::SYN_MIN_MHZ * syn_div)) &&
		(syn_prod <= 16'(scr_pkg::SYN_MAX_MHZ * syn_div));
	wire        syn_lock  = syn_r.en && syn_range &&
		(syn_cnt_r == 12'(P_SYN_LOCK_CYCLES));
	wire        syn_ref_ok = syn_r.ref_sel ? o_osc_en[scr_pkg::SRC_XTAL] : fast_en_r;
	wire [3:0]  src_ready = {syn_lock, o_osc_en[2:1], 1'b1};
	wire        wake      = i_wakeup && ((mode_r == scr_pkg::MODE_SLEEP) ||
		(mode_r == scr_pkg::MODE_PDOWN));

	// A selection is taken only when the source runs; a running source that
	// is switched off falls back to the ring; its ticks are masked off, so the switch then waits for its edge until it is enabled again or i_reset.
	always_comb begin
		sel_nxt = sel_r;
		if (wake) begin
			sel_nxt = scr_pkg::SRC_RING;
		end else if (wr_sel && src_ready[i_wdata[1:0]]) begin
			sel_nxt = scr_pkg::scr_src_e'(i_wdata[scr_pkg::SEL_LSB +: 2]);
		end else if (!src_ready[sel_r]) begin
			sel_nxt = scr_pkg::SRC_RING;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || in_warm) begin
			fast_en_r      <= 1'b0;
			xtal_en_r      <= 1'b0;
			sel_r          <= scr_pkg::SRC_RING;
			syn_r          <= '{en: 1'b0, ref_sel: 1'b0, pre: scr_pkg::SYN_PRE_RST,
				mult: scr_pkg::SYN_MULT_RST, post: scr_pkg::SYN_POST_RST};
			syn_cnt_r      <= 12'h000;
			pfunc_en_r     <= scr_pkg::PFUNC_EN_RST;
			pclk_gate_en_r <= scr_pkg::PCLK_GATE_RST;
			flash_four_r   <= scr_pkg::FLASH_FOUR_RST;
		end else begin
			sel_r <= sel_nxt;
			if (wr_src_ctl) begin
				fast_en_r <= i_wdata[scr_pkg::SRC_CTL_FAST_BIT];
				xtal_en_r <= i_wdata[scr_pkg::SRC_CTL_XTAL_BIT];
			end
			if (wr_syn) begin
				syn_r.en      <= i_wdata[scr_pkg::SYN_EN_BIT];
				syn_r.ref_sel <= i_wdata[scr_pkg::SYN_REF_BIT];
				syn_r.pre     <= i_wdata[scr_pkg::SYN_PRE_LSB +: 4];
				syn_r.mult    <= i_wdata[scr_pkg::SYN_MULT_LSB +: 8];
				syn_r.post    <= i_wdata[scr_pkg::SYN_POST_LSB +: 4];
			end
			// Any reprogramming or a dead reference restarts the settle time.
			if (wr_syn || !syn_r.en || !syn_ref_ok) begin
				syn_cnt_r <= 12'h000;
			end else if (syn_cnt_r != 12'(P_SYN_LOCK_CYCLES)) begin
				syn_cnt_r <= syn_cnt_r + 12'h001;
			end
			if (wr_pfunc) begin
				pfunc_en_r <= i_wdata;
			end
			if (wr_pgate) begin
				pclk_gate_en_r <= i_wdata;
			end
			if (wr_flash) begin
				flash_four_r <= i_wdata[0];
			end
		end
	end

	// ---------------------------------------------------------------
	// Operating mode
	// ---------------------------------------------------------------
	wire [1:0] mode_req = i_wdata[scr_pkg::MODE_LSB +: 2];

	always_ff @(posedge i_sys_clk) begin
		if (i_reset || in_warm || in_por) begin
			mode_r      <= scr_pkg::MODE_INIT;
			sleep_arm_r <= 1'b0;
			pd_arm_r    <= 1'b0;
		end else if (wake) begin
			mode_r      <= scr_pkg::MODE_RUN;
			sleep_arm_r <= 1'b0;
			pd_arm_r    <= 1'b0;
		end else if (wr_mode && (mode_r == scr_pkg::MODE_INIT)) begin
			if (mode_req == scr_pkg::MODE_RUN) begin
				mode_r <= scr_pkg::MODE_RUN;
			end
		end else if (wr_mode && (mode_r == scr_pkg::MODE_RUN)) begin
			sleep_arm_r <= (mode_req == scr_pkg::MODE_SLEEP);
			pd_arm_r    <= (mode_req == scr_pkg::MODE_PDOWN);
		end else if (i_core_wfi && (mode_r == scr_pkg::MODE_RUN)) begin
			if (sleep_arm_r) begin
				mode_r <= scr_pkg::MODE_SLEEP;
			end else if (pd_arm_r) begin
				mode_r <= scr_pkg::MODE_PDOWN;
			end
		end
	end

	// ---------------------------------------------------------------
	// Software reset request
	// ---------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_reset || in_warm) begin
			sw_req_r <= 1'b0;
		end else begin
			sw_req_r <= wr_software_reset_bit && i_wdata[scr_pkg::SW_RESET_BIT];
		end
	end

	// ---------------------------------------------------------------
	// Clock switch and clock enables
	// ---------------------------------------------------------------
	logic              sys_tick;
	logic              sw_busy;
	scr_pkg::scr_src_e sw_cur;

	scr_clk_switch u_switch (
		.i_sys_clk  (i_sys_clk),
		.i_reset    (i_reset),
		.i_src_tick (src_tick),
		.i_sel      (sel_r),
		.o_tick     (sys_tick),
		.o_busy     (sw_busy),
		.o_cur      (sw_cur)
	);

	wire pd_stop    = (mode_r == scr_pkg::MODE_PDOWN);
	wire core_stop  = pd_stop || (mode_r == scr_pkg::MODE_SLEEP);
	wire pclk_next  = sys_tick && !pd_stop;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			clk_en_r <= '0;
		end else begin
			clk_en_r.free_running_core_clock_en <= sys_tick && !pd_stop;
			clk_en_r.hclk_en <= sys_tick && !core_stop;
			clk_en_r.pclk_en <= pclk_next;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_periph
			always_ff @(posedge i_sys_clk) begin
				if (i_reset) begin
					pclk_gate_r[gi] <= 1'b0;
					prst_r[gi]      <= 1'b1;
				end else begin
					pclk_gate_r[gi] <= pclk_next && pclk_gate_en_r[gi];
					prst_r[gi]      <= in_por || (in_warm && prst_en_r[gi]);
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	wire [31:0] rd_mux =
		(i_addr == scr_pkg::OFS_CHIP_ID) ? scr_pkg::CHIP_ID_VAL :
		(i_addr == scr_pkg::OFS_SYSTEM_MODE) ? {26'h0, prior_mode_r, 2'h0, mode_r} :
		(i_addr == scr_pkg::OFS_SW_RESET) ? {30'h0, sw_req_r, 1'b0} :
		(i_addr == scr_pkg::OFS_RESET_SRC_ENABLE) ? {25'h0, rst_en_r} :
		(i_addr == scr_pkg::OFS_RESET_SRC_STATUS) ? {24'h0, rst_stat_r} :
		(i_addr == scr_pkg::OFS_PERIPH_RESET_ENABLE) ? prst_en_r :
		(i_addr == scr_pkg::OFS_PERIPH_FUNC_ENABLE) ? pfunc_en_r :
		(i_addr == scr_pkg::OFS_PERIPH_CLOCK_GATE) ? pclk_gate_en_r :
		(i_addr == scr_pkg::OFS_CLOCK_SOURCE_CONTROL) ? {30'h0, xtal_en_r, fast_en_r} :
		(i_addr == scr_pkg::OFS_CLOCK_SELECT) ? {27'h0, sw_busy, sw_cur, sel_r} :
		(i_addr == scr_pkg::OFS_SYNTH_CONTROL) ? {syn_lock, 11'h0, syn_r.post, syn_r.mult,
			syn_r.pre, 2'h0, syn_r.ref_sel, syn_r.en} :
		(i_addr == scr_pkg::OFS_FLASH_MEMORY_CONTROL) ? {31'h0, flash_four_r} :
		32'h0000_0000;

	always_ff @(posedge i_sys_clk) begin
		if (i_reset) begin
			rdata_r <= 32'h0000_0000;
		end else begin
			rdata_r <= i_rd ? rd_mux : 32'h0000_0000;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign o_rdata               = rdata_r;
	assign o_osc_en              = {syn_r.en, xtal_en_r && fast_en_r, fast_en_r, 1'b1};
	assign o_synth_cfg           = syn_r;
	assign o_clk_en              = clk_en_r;
	assign o_pclk_gate           = pclk_gate_r;
	assign o_periph_func_en      = pfunc_en_r;
	assign o_periph_rst          = prst_r;
	assign o_core_system_reset_n = active;
	assign o_debug_reset_n       = !in_por;
	assign o_warm_reset          = in_warm;
	assign o_flash_wait_four     = flash_four_r;
	assign o_mode                = mode_r;

endmodule
`default_nettype wire

// ---- scr_osc_model.sv ----
// Oscillator model that answers the enable outputs of the unit.
`timescale 1ns/1ns
`default_nettype none
module scr_osc_model (
	input  wire logic [3:0] i_en,
	output var  logic [3:0] o_clk
);
	// A disabled oscillator stops low; these periods keep edges off the system clock edge.
	initial o_clk = 4'h0;
	always #500 o_clk[0] = i_en[0] & ~o_clk[0];
	always #25 o_clk[1] = i_en[1] & ~o_clk[1];
	always #62 o_clk[2] = i_en[2] & ~o_clk[2];
	always #12 o_clk[3] = i_en[3] & ~o_clk[3];
endmodule
`default_nettype wire

// ---- scr_sys_ctrl_checker.sv ----
// Concurrent checks on the ports of the system control unit.
`timescale 1ns/1ns
`default_nettype none
module scr_sys_ctrl_checker (
	input wire logic               i_sys_clk,
	input wire logic               i_reset,
	input wire logic [3:0]         o_osc_en,
	input wire scr_pkg::scr_clk_s  o_clk_en,
	input wire logic [31:0]        o_pclk_gate,
	input wire logic               o_core_system_reset_n,
	input wire logic               o_debug_reset_n,
	input wire logic               o_warm_reset,
	input wire scr_pkg::scr_mode_e o_mode
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_reset);
	ring_on_a: assert property (o_osc_en[0]) else $error("ring off");
	xtal_fast_a: assert property (o_osc_en[2] |-> o_osc_en[1]) else $error("xtal alone");
	free_running_core_clock_pdown_a:
		assert property (o_mode == scr_pkg::MODE_PDOWN && $stable(o_mode) |-> !o_clk_en.free_running_core_clock_en)
		else $error("free_running_core_clock in pdown");
	hclk_sleep_a:
		assert property (o_mode == scr_pkg::MODE_SLEEP && $stable(o_mode) |-> !o_clk_en.hclk_en)
		else $error("hclk in sleep");
	gate_pclk_a:
		assert property (o_pclk_gate != 32'h0 |-> o_clk_en.pclk_en) else $error("gate no pclk");
	debug_kept_a:
		assert property (o_warm_reset |-> o_debug_reset_n && !o_core_system_reset_n)
		else $error("warm hit debug");
	por_release_a:
		assert property ($rose(o_debug_reset_n) |-> o_core_system_reset_n ##1 o_core_system_reset_n)
		else $error("core release");
	init_por_a:
		assert property (!o_debug_reset_n |-> o_mode == scr_pkg::MODE_INIT && o_osc_en == 4'h1)
		else $error("por state");
endmodule
bind scr_sys_ctrl scr_sys_ctrl_checker u_chk (.i_sys_clk, .i_reset, .o_osc_en, .o_clk_en,
	.o_pclk_gate, .o_core_system_reset_n, .o_debug_reset_n, .o_warm_reset, .o_mode);
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the system control unit.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic               i_sys_clk = 1'b0;
	logic               i_reset = 1'b1;
	logic               i_wr = 1'b0;
	logic               i_rd = 1'b0;
	logic               i_core_wfi = 1'b0;
	logic               i_wakeup = 1'b0;
	logic [6:0]         ev = 7'h0;
	logic [7:0]         i_addr = 8'h0;
	logic [31:0]        i_wdata = 32'h0;
	logic [31:0]        o_rdata, o_pclk_gate, o_periph_rst, o_periph_func_en, v, g;
	scr_pkg::scr_synth_cfg_s o_synth_cfg;
	logic [3:0]         i_osc_clk, o_osc_en;
	logic               o_core_system_reset_n, o_debug_reset_n, o_warm_reset, o_flash_wait_four;
	scr_pkg::scr_clk_s  o_clk_en;
	scr_pkg::scr_mode_e o_mode;
	int                 bad_count = 0, checked = 0, seed = 19879, hc, fc;
	localparam int      ST [8] = '{5, 4, 1, 0, 3, 7, 6, 2};
	scr_sys_ctrl #(.P_POR_RING_TICKS(4), .P_SYN_LOCK_CYCLES(8)) u_dut (.*,
		.i_wdt_rst(ev[0]), .i_lvd_rst(ev[1]),
		.i_mclk_fail(ev[2]), .i_xtal_fail(ev[3]), .i_cpu_req_rst(ev[4]), .i_vdc_drop(ev[5]),
		.i_external_reset_n_pin(!ev[6]));
	scr_osc_model u_osc (.i_en(o_osc_en), .o_clk(i_osc_clk));
	initial begin
		#3;
		forever #10 i_sys_clk = ~i_sys_clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		tick(1);
		i_wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a);
		@(posedge i_sys_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		tick(1);
		i_rd <= 1'b0;
		v = o_rdata;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic ok(input bit c);
		chk("wait", 32'h1, {31'h0, c});
		if (!c) conclude();
	endtask
	task automatic wsel(input logic [1:0] s);
		v = 32'hffff_ffff;
		for (int i = 0; i < 200 && v[4:0] !== {1'b0, s, s}; i++) rreg(8'h44);
		ok(v[4:0] === {1'b0, s, s});
	endtask
	function automatic logic [31:0] syn(input logic [7:0] m, input logic lk);
		int f;
		f = scr_pkg::FAST_MHZ * m;
		return {lk && f >= 8 && f <= 80, 11'h0, 4'h1, m, 8'h11};
	endfunction
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		tick(6);
		i_reset <= 1'b0;
		rreg(8'h40);
		chk("source ctl", 32'h0, v);
		rreg(8'h60);
		chk("synth", 32'h0004_1010, v);
		rreg(8'h1c);
		chk("por flag", {24'h0, scr_pkg::RESET_STAT_RST}, v);
		chk("func en", scr_pkg::PFUNC_EN_RST, o_periph_func_en);
		for (int i = 0; i < 2000 && o_core_system_reset_n !== 1'b1; i++) tick(1);
		ok(o_core_system_reset_n === 1'b1);
		wreg(8'h04, 32'h0);
		wreg(8'h40, 32'h2);
		chk("osc en", 32'h1, {28'h0, o_osc_en});
		wreg(8'h40, 32'h3);
		chk("osc en", 32'h7, {28'h0, o_osc_en});
		wreg(8'h44, 32'h1);
		wsel(2'h1);
		g = $random(seed);
		wreg(8'h30, g);
		v = 32'h0;
		repeat (80) begin
			tick(1);
			v = v | o_pclk_gate;
		end
		chk("gated pulses", g, v);
		wreg(8'h28, ~g);
		chk("func en", ~g, o_periph_func_en);
		wreg(8'h88, 32'h0);
		chk("flash four", 32'h0, {31'h0, o_flash_wait_four});
		for (int m = 5; m > 3; m--) begin
			wreg(8'h60, syn(m[7:0], 1'b0));
			chk("synth cfg", {14'h0, 2'b10, 4'h1, m[7:0], 4'h1}, {14'h0, o_synth_cfg});
			tick(40);
			rreg(8'h60);
			chk("synth lock", syn(m[7:0], 1'b1), v);
		end
		wreg(8'h88, 32'h1);
		wreg(8'h44, 32'h3);
		wsel(2'h3);
		for (int md = 1; md < 3; md++) begin
			wreg(8'h04, md);
			i_core_wfi <= 1'b1;
			tick(1);
			i_core_wfi <= 1'b0;
			tick(2);
			chk("mode", md, {30'h0, o_mode});
			hc = 0;
			fc = 0;
			repeat (120) begin
				tick(1);
				hc += o_clk_en.hclk_en;
				fc += o_clk_en.free_running_core_clock_en;
			end
			chk("hclk", 32'h0, 32'(hc));
			chk("free_running_core_clock", {31'h0, md == 1}, {31'h0, fc > 0});
			i_wakeup <= 1'b1;
			tick(1);
			i_wakeup <= 1'b0;
			wsel(2'h0);
		end
		ev[0] <= 1'b1;
		tick(1);
		ev[0] <= 1'b0;
		tick(3);
		chk("warm", 32'h0, {31'h0, o_warm_reset});
		wreg(8'h18, 32'h7f);
		for (int k = 0; k < 8; k++) begin
			wreg(8'h1c, 32'hff);
			if (k < 7) ev[k] <= 1'b1;
			else wreg(8'h08, 32'h2);
			tick(1);
			ev <= 7'h0;
			for (int i = 0; i < 10 && o_warm_reset !== 1'b1; i++) tick(1);
			ok(o_warm_reset === 1'b1);
			tick(1);
			chk("periph rst", scr_pkg::PRST_EN_RST, o_periph_rst);
			for (int i = 0; i < 100 && o_warm_reset !== 1'b0; i++) tick(1);
			ok(o_warm_reset === 1'b0);
			rreg(8'h1c);
			chk("status", 32'h1 << ST[k], v);
			chk("periph rst", 32'h0, o_periph_rst);
			rreg(8'h04);
			if (k == 0) chk("prior mode", 32'h3, v);
			if (k == 0) chk("func en", scr_pkg::PFUNC_EN_RST, o_periph_func_en);
		end
		conclude();
	end
endmodule
`default_nettype wire
